// file: deser_out_pkg.sv
package deser_out_pkg;
  // System clock and register map
  localparam int CLK_KHZ = 100000;
  localparam int ADDR_W  = 8;
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MCLK_DIV  = 8'h04;
  localparam logic [7:0] OFS_UART_DIV  = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0C;
  localparam logic [7:0] OFS_ERR_COUNT = 8'h10;

  // Control register fields
  localparam int CTRL_W           = 5;
  localparam int CTRL_OUT_EN      = 0;
  localparam int CTRL_I2S_EN      = 1;
  localparam int CTRL_MCLK_EN     = 2;
  localparam int CTRL_FULL_DUPLEX = 3;
  localparam int CTRL_BYPASS      = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h0B;

  // Status register fields
  localparam int STAT_W          = 6;
  localparam int STAT_WIDE       = 0;
  localparam int STAT_SPREAD     = 1;
  localparam int STAT_LOW_RANGE  = 2;
  localparam int STAT_POWERED    = 3;
  localparam int STAT_ALIGNED    = 4;
  localparam int STAT_RATE_FAULT = 5;

  // Clock dividers
  localparam int MCLK_DIV_W = 8;
  localparam logic [MCLK_DIV_W-1:0] MCLK_DIV_RESET = 8'h04;
  localparam int UART_MIN_KBPS = 100;
  localparam int UART_MAX_KBPS = 1000;
  localparam int UART_DIV_W    = 10;
  localparam logic [UART_DIV_W-1:0] UART_DIV_MIN = UART_DIV_W'(CLK_KHZ / UART_MAX_KBPS);
  localparam logic [UART_DIV_W-1:0] UART_DIV_MAX = UART_DIV_W'(CLK_KHZ / UART_MIN_KBPS);

  // Parallel rate limits in kHz and their word periods in clock cycles
  localparam int F24_MIN_KHZ = 8330;
  localparam int F24_SPLIT_KHZ = 16660;
  localparam int F24_MAX_KHZ = 104000;
  localparam int F32_MIN_KHZ = 6250;
  localparam int F32_SPLIT_KHZ = 12500;
  localparam int F32_MAX_KHZ = 78000;
  localparam int PER_W = 16;
  localparam logic [PER_W-1:0] P24_FAST  = PER_W'((CLK_KHZ + F24_MAX_KHZ - 1) / F24_MAX_KHZ);
  localparam logic [PER_W-1:0] P24_SPLIT = PER_W'(CLK_KHZ / F24_SPLIT_KHZ);
  localparam logic [PER_W-1:0] P24_SLOW  = PER_W'(CLK_KHZ / F24_MIN_KHZ);
  localparam logic [PER_W-1:0] P32_FAST  = PER_W'((CLK_KHZ + F32_MAX_KHZ - 1) / F32_MAX_KHZ);
  localparam logic [PER_W-1:0] P32_SPLIT = PER_W'(CLK_KHZ / F32_SPLIT_KHZ);
  localparam logic [PER_W-1:0] P32_SLOW  = PER_W'(CLK_KHZ / F32_MIN_KHZ);

  // Parallel word layout
  localparam int DOUT_W     = 29;
  localparam int NARROW_W   = 21;
  localparam int MCLK_BIT   = 28;
  localparam int WS_BIT     = 29;
  localparam int SCK_BIT    = 30;
  localparam int SD_BIT     = 31;
  localparam int LAST_BYTE  = 3;
  localparam logic [5:0] K28_NEG = 6'h0F;
  localparam logic [5:0] K28_POS = 6'h30;
  localparam int SYNC_STAGES = 2;
endpackage

// file: line_decoder.sv
`timescale 1ns/1ps
module line_decoder (
  symbol_if.decoder sym
);
  // 6b group to 5 bits, top bit flags an illegal code
  function automatic logic [5:0] dec6(input logic [5:0] c);
    unique case (c)
      6'h27, 6'h18: dec6 = 6'h00;
      6'h1D, 6'h22: dec6 = 6'h01;
      6'h2D, 6'h12: dec6 = 6'h02;
      6'h31:        dec6 = 6'h03;
      6'h35, 6'h0A: dec6 = 6'h04;
      6'h29:        dec6 = 6'h05;
      6'h19:        dec6 = 6'h06;
      6'h38, 6'h07: dec6 = 6'h07;
      6'h39, 6'h06: dec6 = 6'h08;
      6'h25:        dec6 = 6'h09;
      6'h15:        dec6 = 6'h0A;
      6'h34:        dec6 = 6'h0B;
      6'h0D:        dec6 = 6'h0C;
      6'h2C:        dec6 = 6'h0D;
      6'h1C:        dec6 = 6'h0E;
      6'h17, 6'h28: dec6 = 6'h0F;
      6'h1B, 6'h24: dec6 = 6'h10;
      6'h23:        dec6 = 6'h11;
      6'h13:        dec6 = 6'h12;
      6'h32:        dec6 = 6'h13;
      6'h0B:        dec6 = 6'h14;
      6'h2A:        dec6 = 6'h15;
      6'h1A:        dec6 = 6'h16;
      6'h3A, 6'h05: dec6 = 6'h17;
      6'h33, 6'h0C: dec6 = 6'h18;
      6'h26:        dec6 = 6'h19;
      6'h16:        dec6 = 6'h1A;
      6'h36, 6'h09: dec6 = 6'h1B;
      6'h0E, 6'h0F, 6'h30: dec6 = 6'h1C;
      6'h2E, 6'h11: dec6 = 6'h1D;
      6'h1E, 6'h21: dec6 = 6'h1E;
      6'h2B, 6'h14: dec6 = 6'h1F;
      default:      dec6 = 6'h20;
    endcase
  endfunction

  // 4b group to 3 bits, top bit flags an illegal code
  function automatic logic [3:0] dec4(input logic [3:0] c);
    unique case (c)
      4'hB, 4'h4:             dec4 = 4'h0;
      4'h9:                   dec4 = 4'h1;
      4'h5:                   dec4 = 4'h2;
      4'hC, 4'h3:             dec4 = 4'h3;
      4'hD, 4'h2:             dec4 = 4'h4;
      4'hA:                   dec4 = 4'h5;
      4'h6:                   dec4 = 4'h6;
      4'hE, 4'h1, 4'h7, 4'h8: dec4 = 4'h7;
      default:                dec4 = 4'h8;
    endcase
  endfunction

  logic [5:0] lo6;
  logic [3:0] hi4;

  // Symbol bits 9:4 are abcdei, 3:0 are fghj
  always_comb begin
    lo6          = dec6(sym.symbol[9:4]);
    hi4          = dec4(sym.symbol[3:0]);
    sym.data     = {hi4[2:0], lo6[4:0]};
    sym.code_err = lo6[5] | hi4[3];
    sym.is_k     = (sym.symbol[9:4] == deser_out_pkg::K28_NEG) ||
                   (sym.symbol[9:4] == deser_out_pkg::K28_POS);
  end
endmodule

// file: link_source.sv
`timescale 1ns/1ps
// Serializer stand-in: one comma then four coded bytes per frame
module link_source (
  output logic       link_clock_o,
  output logic [9:0] link_symbol_o
);
  initial begin
    link_clock_o  = 1'b0;
    link_symbol_o = 10'h000;
  end

  // Symbol set while the clock is low and held through the rise
  task automatic put(input logic [9:0] sym);
    link_symbol_o = sym;
    #62.5 link_clock_o = 1'b1;
    #62.5 link_clock_o = 1'b0;
  endtask

  // Comma aligns, then byte 0 first; clock stands low between frames
  task automatic frame(input logic [39:0] syms);
    put(10'h0FA);
    for (int i = 0; i < 4; i++) begin
      put(syms[i*10 +: 10]);
    end
    link_symbol_o = ~link_symbol_o;
  endtask
endmodule

// file: serial_link_parallel_output.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - Width select low: drive bits 0 to 20
// - Narrow mode holds bits 21 to 28 low
// - Width select high: drive bits 0 to 28
// - Bit 28 may carry audio master clock
// - Data launched for sampling on chosen edge
// - Edge select low rising, high falling
// - Spread enable latched at power-up, wake
// - Latched spread enable dithers output timing
// - Range select high: low rate range
// - Range select low: high rate range
// - Slowest clock 6.25 or 8.33 MHz
// - Outputs enabled after reset, register controlled
// - 21 or 29 bits plus audio
// - Audio 8 to 192 kHz, 4-32 bits
// - Control channel half or full duplex
// - Control channel 100 kbps to 1 Mbps
// - Control channel base or bypass format
// - Serial symbols decoded as 8b/10b
// - Power-down input active low
module serial_link_parallel_output #(
  parameter int PHASE_DLY = 4,
  parameter int SS_SPAN   = 2
) (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic        link_clock_i,
  input  wire logic [9:0]  link_symbol_i,
  input  wire logic        bus_width_select_i,
  input  wire logic        edge_select_input_i,
  input  wire logic        spread_enable_input_i,
  input  wire logic        rate_range_select_i,
  input  wire logic        power_down_n_i,
  output logic      [28:0] dout_o,
  output logic             parallel_clock_out_o,
  output logic             i2s_ws_o,
  output logic             i2s_sck_o,
  output logic             i2s_sd_o,
  output logic             cc_full_duplex_o,
  output logic             cc_bypass_o,
  output logic             cc_bit_tick_o
);
  localparam int IN_W = 16;
  localparam int PC_W = 4;

  typedef enum {PS_IDLE, PS_DITHER} present_state_e;

  logic [IN_W-1:0] meta_reg;
  logic [IN_W-1:0] sync_reg;
  logic            lclk_prev_reg;
  logic            pd_prev_reg;
  logic [1:0]      startup_reg;
  logic            ss_latch_reg;
  logic [deser_out_pkg::CTRL_W-1:0]     ctrl_reg;
  logic [deser_out_pkg::MCLK_DIV_W-1:0] mclk_div_reg;
  logic [deser_out_pkg::UART_DIV_W-1:0] uart_div_reg;
  logic [deser_out_pkg::UART_DIV_W-1:0] uart_div_next;
  logic [7:0]      err_count_reg;
  logic [31:0]     rdata_reg;
  logic [1:0]      byte_idx_reg;
  logic [23:0]     asm_reg;
  logic            aligned_reg;
  logic            word_done_reg;
  logic [31:0]     pending_reg;
  logic [31:0]     word_reg;
  present_state_e  state_reg;
  logic [PC_W-1:0] dither_cnt_reg;
  logic [PC_W-1:0] tri_reg;
  logic            tri_up_reg;
  logic            phase_reg;
  logic [PC_W-1:0] phase_cnt_reg;
  logic [deser_out_pkg::PER_W-1:0] period_reg;
  logic            seen_reg;
  logic            rate_fault_reg;
  logic            mclk_reg;
  logic [28:0]     dout_reg;
  logic            pclk_reg;
  logic [2:0]      i2s_reg;
  logic            lclk_s, bws_s, es_s, spread_enable_input_s, drs_s, pd_s;
  logic [9:0]      sym_s;
  logic            link_edge, present, live, mclk_tick;
  logic [deser_out_pkg::PER_W-1:0] lo_bound, hi_bound;
  logic [deser_out_pkg::STAT_W-1:0] status;

  symbol_if sym ();

  // Two-stage synchroniser for every pin input
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {link_symbol_i, link_clock_i, bus_width_select_i, edge_select_input_i,
                   spread_enable_input_i, rate_range_select_i, power_down_n_i};
      sync_reg <= meta_reg;
    end
  end

  assign {sym_s, lclk_s, bws_s, es_s, spread_enable_input_s, drs_s, pd_s} = sync_reg;
  assign link_edge = lclk_s && !lclk_prev_reg;
  assign sym.symbol = sym_s;
  assign live = ctrl_reg[deser_out_pkg::CTRL_OUT_EN] && pd_s;

  line_decoder u_dec (
    .sym (sym.decoder)
  );

  // Spread enable is caught once after reset and on each wake-up
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lclk_prev_reg <= 1'b0;
      pd_prev_reg   <= 1'b0;
      startup_reg   <= 2'(deser_out_pkg::SYNC_STAGES + 1); // Pin reaches the synchroniser output two edges after reset and is latched on the third
      ss_latch_reg  <= 1'b0;
    end else begin
      lclk_prev_reg <= lclk_s;
      pd_prev_reg   <= pd_s;
      if (startup_reg != 2'h0) begin
        startup_reg <= startup_reg - 2'h1;
      end
      if (startup_reg == 2'h1 || (pd_s && !pd_prev_reg)) begin
        ss_latch_reg <= spread_enable_input_s;
      end
    end
  end

  // Register writes
  always_comb begin
    uart_div_next = reg_wdata_i[deser_out_pkg::UART_DIV_W-1:0];
    if (uart_div_next < deser_out_pkg::UART_DIV_MIN) begin
      uart_div_next = deser_out_pkg::UART_DIV_MIN;
    end else if (uart_div_next > deser_out_pkg::UART_DIV_MAX) begin
      uart_div_next = deser_out_pkg::UART_DIV_MAX;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg     <= deser_out_pkg::CTRL_RESET;
      mclk_div_reg <= deser_out_pkg::MCLK_DIV_RESET;
      uart_div_reg <= deser_out_pkg::UART_DIV_MIN;
    end else if (reg_write_i) begin
      if (reg_addr_i == deser_out_pkg::OFS_CTRL) begin
        ctrl_reg <= reg_wdata_i[deser_out_pkg::CTRL_W-1:0];
      end
      if (reg_addr_i == deser_out_pkg::OFS_MCLK_DIV) begin
        mclk_div_reg <= reg_wdata_i[deser_out_pkg::MCLK_DIV_W-1:0];
      end
      if (reg_addr_i == deser_out_pkg::OFS_UART_DIV) begin
        uart_div_reg <= uart_div_next;
      end
    end
  end

  // Register reads, data one cycle after the strobe
  always_comb begin
    status = '0;
    status[deser_out_pkg::STAT_WIDE]       = bws_s;
    status[deser_out_pkg::STAT_SPREAD]     = ss_latch_reg;
    status[deser_out_pkg::STAT_LOW_RANGE]  = drs_s;
    status[deser_out_pkg::STAT_POWERED]    = pd_s;
    status[deser_out_pkg::STAT_ALIGNED]    = aligned_reg;
    status[deser_out_pkg::STAT_RATE_FAULT] = rate_fault_reg;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_reg <= '0;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        deser_out_pkg::OFS_CTRL:      rdata_reg <= 32'(ctrl_reg);
        deser_out_pkg::OFS_MCLK_DIV:  rdata_reg <= 32'(mclk_div_reg);
        deser_out_pkg::OFS_UART_DIV:  rdata_reg <= 32'(uart_div_reg);
        deser_out_pkg::OFS_STATUS:    rdata_reg <= 32'(status);
        deser_out_pkg::OFS_ERR_COUNT: rdata_reg <= 32'(err_count_reg);
        default:                      rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  // Byte alignment on comma symbols and word assembly, low byte first
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_idx_reg  <= '0;
      asm_reg       <= '0;
      aligned_reg   <= 1'b0;
      word_done_reg <= 1'b0;
      pending_reg   <= '0;
      err_count_reg <= '0;
    end else begin
      word_done_reg <= 1'b0;
      if (!pd_s) begin
        aligned_reg  <= 1'b0;
        byte_idx_reg <= '0;
      end else if (link_edge) begin
        if (sym.code_err) begin
          aligned_reg <= 1'b0;
          if (err_count_reg != 8'hFF) begin
            err_count_reg <= err_count_reg + 8'h01;
          end
        end else if (sym.is_k) begin
          aligned_reg  <= 1'b1;
          byte_idx_reg <= '0;
        end else if (aligned_reg) begin
          byte_idx_reg <= byte_idx_reg + 2'h1;
          asm_reg      <= {sym.data, asm_reg[23:8]};
          if (byte_idx_reg == 2'(deser_out_pkg::LAST_BYTE)) begin
            word_done_reg <= 1'b1;
            pending_reg   <= {sym.data, asm_reg};
          end
        end
      end
    end
  end

  // Presentation: optional dither delay, then new data with clock phase low
  assign present = (state_reg == PS_IDLE && word_done_reg && !ss_latch_reg) ||
                   (state_reg == PS_DITHER && dither_cnt_reg == '0);

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg      <= PS_IDLE;
      dither_cnt_reg <= '0;
      tri_reg        <= '0;
      tri_up_reg     <= 1'b1;
    end else begin
      unique case (state_reg)
        PS_IDLE: begin
          if (word_done_reg && ss_latch_reg) begin
            state_reg      <= PS_DITHER;
            dither_cnt_reg <= tri_reg;
          end
        end
        PS_DITHER: begin
          if (dither_cnt_reg == '0) begin
            state_reg <= PS_IDLE;
          end else begin
            dither_cnt_reg <= dither_cnt_reg - PC_W'(1);
          end
        end
      endcase
      if (present) begin
        if (tri_up_reg) begin
          tri_reg    <= tri_reg + PC_W'(1);
          tri_up_reg <= (tri_reg + PC_W'(1) < PC_W'(SS_SPAN));
        end else begin
          tri_reg    <= tri_reg - PC_W'(1);
          tri_up_reg <= (tri_reg == PC_W'(1));
        end
      end
    end
  end

  // Word register and sampling phase of the parallel clock
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_reg      <= '0;
      phase_reg     <= 1'b1;
      phase_cnt_reg <= '0;
    end else if (present) begin
      word_reg      <= pending_reg;
      phase_reg     <= 1'b0;
      phase_cnt_reg <= PC_W'(PHASE_DLY - 1);
    end else if (!phase_reg) begin
      if (phase_cnt_reg == '0) begin
        phase_reg <= 1'b1;
      end else begin
        phase_cnt_reg <= phase_cnt_reg - PC_W'(1);
      end
    end
  end

  // Word period monitor against the selected rate range
  always_comb begin
    if (bws_s) begin
      lo_bound = drs_s ? deser_out_pkg::P32_SPLIT : deser_out_pkg::P32_FAST;
      hi_bound = drs_s ? deser_out_pkg::P32_SLOW : deser_out_pkg::P32_SPLIT;
    end else begin
      lo_bound = drs_s ? deser_out_pkg::P24_SPLIT : deser_out_pkg::P24_FAST;
      hi_bound = drs_s ? deser_out_pkg::P24_SLOW : deser_out_pkg::P24_SPLIT;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      period_reg     <= '0;
      seen_reg       <= 1'b0;
      rate_fault_reg <= 1'b0;
    end else if (!pd_s) begin
      seen_reg       <= 1'b0;
      rate_fault_reg <= 1'b0;
    end else if (present) begin
      period_reg <= deser_out_pkg::PER_W'(1);
      seen_reg   <= 1'b1;
      if (seen_reg) begin
        rate_fault_reg <= (period_reg < lo_bound) || (period_reg > hi_bound);
      end
    end else if (period_reg != '1) begin
      period_reg <= period_reg + deser_out_pkg::PER_W'(1);
    end
  end

  // Audio master clock from a programmable divider
  tick_divider #(.W(deser_out_pkg::MCLK_DIV_W)) u_mclk_div (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .run_i    (ctrl_reg[deser_out_pkg::CTRL_MCLK_EN]),
    .div_i    (mclk_div_reg),
    .tick_o   (mclk_tick)
  );

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mclk_reg <= 1'b0;
    end else if (!ctrl_reg[deser_out_pkg::CTRL_MCLK_EN]) begin
      mclk_reg <= 1'b0;
    end else if (mclk_tick) begin
      mclk_reg <= !mclk_reg;
    end
  end

  // Control channel bit-rate tick and mode outputs
  tick_divider #(.W(deser_out_pkg::UART_DIV_W)) u_uart_div (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .run_i    (pd_s),
    .div_i    (uart_div_reg),
    .tick_o   (cc_bit_tick_o)
  );

  assign cc_full_duplex_o = ctrl_reg[deser_out_pkg::CTRL_FULL_DUPLEX];
  assign cc_bypass_o      = ctrl_reg[deser_out_pkg::CTRL_BYPASS];

  // Output flops: width masking, master clock, edge select, enable
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dout_reg <= '0;
      pclk_reg <= 1'b0;
      i2s_reg  <= '0;
    end else if (!live) begin
      dout_reg <= '0;
      pclk_reg <= 1'b0;
      i2s_reg  <= '0;
    end else begin
      dout_reg[deser_out_pkg::NARROW_W-1:0] <= word_reg[deser_out_pkg::NARROW_W-1:0];
      if (bws_s) begin
        dout_reg[27:21] <= word_reg[27:21];
        dout_reg[deser_out_pkg::MCLK_BIT] <= ctrl_reg[deser_out_pkg::CTRL_MCLK_EN] ?
                                             mclk_reg : word_reg[deser_out_pkg::MCLK_BIT];
      end else begin
        dout_reg[28:21] <= '0;
      end
      pclk_reg <= phase_reg ^ es_s;
      i2s_reg  <= ctrl_reg[deser_out_pkg::CTRL_I2S_EN] ?
                  {word_reg[deser_out_pkg::SD_BIT], word_reg[deser_out_pkg::SCK_BIT],
                   word_reg[deser_out_pkg::WS_BIT]} : 3'h0;
    end
  end

  assign dout_o               = dout_reg;
  assign parallel_clock_out_o = pclk_reg;
  assign {i2s_sd_o, i2s_sck_o, i2s_ws_o} = i2s_reg;
  assign reg_rdata_o          = rdata_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_narrow_upper_low: assert property (!bws_s ##1 !bws_s |=> dout_o[28:21] == 8'h00)
    else $error("upper bits active in narrow mode");
  a_wide_bits_pass: assert property (live && bws_s ##1 live && bws_s |=>
    dout_o[27:21] == $past(word_reg[27:21]))
    else $error("wide bits not passed");
  a_low_bits_pass: assert property (live |=> dout_o[20:0] == $past(word_reg[20:0]))
    else $error("low bits not passed");
  a_sample_phase: assert property (present |=> !phase_reg ##[1:8] phase_reg)
    else $error("sampling edge missing");
  a_edge_polarity: assert property (live && !phase_reg && es_s |=> parallel_clock_out_o)
    else $error("clock polarity wrong");
  a_spread_hold: assert property (startup_reg == 2'h0 && !(pd_s && !pd_prev_reg)
    |=> $stable(ss_latch_reg))
    else $error("spread latch changed");
  a_no_spread: assert property (word_done_reg && !ss_latch_reg && state_reg == PS_IDLE
    |-> present)
    else $error("unspread word delayed");
  a_spread_bound: assert property (word_done_reg && ss_latch_reg && state_reg == PS_IDLE
    |=> ##[0:15] present)
    else $error("dithered word lost");
  a_outputs_off: assert property (!live |=> dout_o == '0 && !parallel_clock_out_o)
    else $error("disabled outputs active");
  a_uart_range: assert property (uart_div_reg >= deser_out_pkg::UART_DIV_MIN &&
    uart_div_reg <= deser_out_pkg::UART_DIV_MAX)
    else $error("uart divider out of range");
  a_err_count: assert property (pd_s && link_edge && sym.code_err && err_count_reg != 8'hFF
    |=> err_count_reg == $past(err_count_reg) + 8'h01)
    else $error("decode error not counted");

  c_wide_word: cover property (present && bws_s);
  c_spread_word: cover property (present && state_reg == PS_DITHER);
  c_reenable: cover property (!live ##1 live);
  c_code_err: cover property (link_edge && sym.code_err);
endmodule

// file: serial_link_parallel_output_bench.sv
`timescale 1ns/1ps
module serial_link_parallel_output_bench;
  logic        clock_i     = 1'b0;
  logic        arst_n_i    = 1'b0;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i  = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        width_sel   = 1'b1;
  logic        edge_sel    = 1'b0;
  logic        spread_pin  = 1'b0;
  logic        range_sel   = 1'b1;
  logic        pd_n        = 1'b1;
  logic [31:0] reg_rdata_o;
  logic [31:0] rdv;
  logic [28:0] dout_o;
  logic        par_clk, ws_o, sck_o, sd_o, fd_o, byp_o, tick;
  logic        link_clk;
  logic [9:0]  link_sym;
  int          mismatches = 0;
  int          n_tests    = 0;
  int          cycles     = 0;
  // Coded bytes 07 15 A3 E5, byte 0 in the low ten bits
  localparam logic [39:0] WORD = {10'h29E, 10'h31A, 10'h2AB, 10'h38B};

  always #5 clock_i = ~clock_i;

  link_source src (.link_clock_o(link_clk), .link_symbol_o(link_sym));

  serial_link_parallel_output DUT (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .link_clock_i(link_clk), .link_symbol_i(link_sym),
    .bus_width_select_i(width_sel), .edge_select_input_i(edge_sel),
    .spread_enable_input_i(spread_pin), .rate_range_select_i(range_sel),
    .power_down_n_i(pd_n), .dout_o(dout_o), .parallel_clock_out_o(par_clk),
    .i2s_ws_o(ws_o), .i2s_sck_o(sck_o), .i2s_sd_o(sd_o), .cc_full_duplex_o(fd_o),
    .cc_bypass_o(byp_o), .cc_bit_tick_o(tick)
  );

  // Verdict and end of run
  task automatic close_out;
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1 rdv = reg_rdata_o;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // One frame, then the word must sit on the pins at the sampling level
  task automatic word(input logic [28:0] exp);
    src.frame(WORD);
    settle(12);
    check("dout", dout_o, exp);
    check("pclk", par_clk, !edge_sel);
  endtask

  task automatic t_regs;
    int ticks;
    ticks = 0;
    rd(8'h00);
    check("ctrl", rdv, 32'h0000_000B);
    rd(8'h14);
    check("unmapped", rdv, 32'h0000_0000);
    rd(8'h0C);
    check("status", rdv, 32'h0000_000D);
    wr(8'h00, 32'h0000_0013);
    settle(1);
    check("bypass", {fd_o, byp_o}, 32'h0000_0001);
    wr(8'h00, 32'h0000_000B);
    settle(1);
    check("duplex", {fd_o, byp_o}, 32'h0000_0002);
    wr(8'h08, 32'h0000_000A);
    rd(8'h08);
    check("uart low", rdv, 32'h0000_0064);
    // Any 200 consecutive cycles hold exactly two bit ticks at a divider of 100
    repeat (200) begin
      @(posedge clock_i);
      #1;
      if (tick) ticks++;
    end
    check("uart ticks", ticks, 32'h0000_0002);
    wr(8'h08, 32'h0000_03FF);
    rd(8'h08);
    check("uart high", rdv, 32'h0000_03E8);
  endtask

  task automatic t_modes;
    word(29'h05A3_1507);
    check("audio", {ws_o, sck_o, sd_o}, 32'h0000_0007);
    @(posedge clock_i);
    width_sel <= 1'b0;
    edge_sel  <= 1'b1;
    settle(4);
    word(29'h0003_1507);
  endtask

  task automatic t_off;
    wr(8'h00, 32'h0000_000A);
    src.frame(WORD);
    settle(12);
    check("off", {par_clk, dout_o}, 32'h0000_0000);
    wr(8'h00, 32'h0000_000B);
    word(29'h0003_1507);
  endtask

  task automatic t_power;
    @(posedge clock_i);
    spread_pin <= 1'b1;
    range_sel  <= 1'b0;
    settle(4);
    rd(8'h0C);
    check("no relatch", rdv[2:1], 32'h0000_0000);
    @(posedge clock_i);
    pd_n <= 1'b0;
    settle(4);
    check("asleep", dout_o, 32'h0000_0000);
    rd(8'h0C);
    check("powered", rdv[3], 32'h0000_0000);
    @(posedge clock_i);
    pd_n      <= 1'b1;
    width_sel <= 1'b1;
    settle(4);
    rd(8'h0C);
    check("relatch", rdv[1], 32'h0000_0001);
    word(29'h05A3_1507);
  endtask

  // One illegal symbol: counted, alignment dropped, next comma recovers
  task automatic t_err;
    src.put(10'h000);
    settle(6);
    rd(8'h10);
    check("errors", rdv, 32'h0000_0001);
    rd(8'h0C);
    check("aligned", rdv[4], 32'h0000_0000);
    word(29'h05A3_1507);
  endtask

  // Master clock on the top data bit toggles every two cycles
  task automatic t_mclk;
    int flips;
    logic prev;
    flips = 0;
    wr(8'h04, 32'h0000_0002);
    wr(8'h00, 32'h0000_000F);
    settle(8);
    prev = dout_o[28];
    repeat (40) begin
      @(posedge clock_i);
      #1;
      if (dout_o[28] !== prev) flips++;
      prev = dout_o[28];
    end
    check("mclk flips", flips, 32'h0000_0014);
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    check("reset duplex", {fd_o, dout_o}, 32'h2000_0000);
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_modes();
    t_off();
    t_power();
    t_err();
    t_mclk();
    close_out();
  end
endmodule

// file: symbol_if.sv
`timescale 1ns/1ps
interface symbol_if;
  logic [9:0] symbol;
  logic [7:0] data;
  logic       is_k;
  logic       code_err;
  modport source  (output symbol, input data, is_k, code_err);
  modport decoder (input symbol, output data, is_k, code_err);
endinterface

// file: tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
  parameter int W = 8
) (
  input  wire logic         clock_i,
  input  wire logic         arst_n_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);
  logic [W-1:0] count_reg;

  // One-cycle tick every div_i cycles while running
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= '0;
    end else if (!run_i || tick_o) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + W'(1);
    end
  end

  assign tick_o = run_i && (count_reg + W'(1) >= div_i);
endmodule
